/* verilog/pmwc_top.sv */
// Power mode and wake-up controller: clock select, halt modes, wake-up, Wishbone slave
`timescale 1ns/10ps

module pmwc_top #(
    parameter int PA_WIDTH  = 8,
    parameter int INT_COUNT = 4
) (
    input  wire logic                 ref_clk,
    input  wire logic                 reset_n,
    // Wishbone classic slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    // Core side, same clock
    input  wire logic                 halt_exec_i,
    input  wire logic                 clr_wdt_exec_i,
    input  wire logic                 wdt_enable_i,
    input  wire logic                 wdt_overflow_i,
    input  wire logic [INT_COUNT-1:0] int_req_i,
    input  wire logic [INT_COUNT-1:0] int_en_i,
    input  wire logic                 stack_full_i,
    // Asynchronous inputs
    input  wire logic [PA_WIDTH-1:0]  porta_i,
    input  wire logic                 hs_osc_ready_i,
    input  wire logic                 ls_osc_ready_i,
    // Controls out
    output logic      [2:0]           sys_clk_sel_q,
    output logic                      hs_osc_run_q,
    output logic                      ls_subclock_run_q,
    output logic                      cpu_halt_q,
    output logic                      wdt_clear_q,
    output logic                      wdt_run_q,
    output logic                      resume_next_q,
    output logic                      int_service_q,
    output logic                      pc_sp_reset_q
);

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers for pins and oscillator ready levels
    logic [PA_WIDTH-1:0] pa_s1_q, pa_s2_q, pa_s3_q;
    logic                hs_rdy_s1_q, hs_rdy_s2_q;
    logic                ls_rdy_s1_q, ls_rdy_s2_q;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pa_s1_q     <= '1;
            pa_s2_q     <= '1;
            pa_s3_q     <= '1;
            hs_rdy_s1_q <= 1'b0;
            hs_rdy_s2_q <= 1'b0;
            ls_rdy_s1_q <= 1'b0;
            ls_rdy_s2_q <= 1'b0;
        end else begin
            pa_s1_q     <= porta_i;
            pa_s2_q     <= pa_s1_q;
            pa_s3_q     <= pa_s2_q;
            hs_rdy_s1_q <= hs_osc_ready_i;
            hs_rdy_s2_q <= hs_rdy_s1_q;
            ls_rdy_s1_q <= ls_osc_ready_i;
            ls_rdy_s2_q <= ls_rdy_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software state and controller state
    logic [2:0]          clk_sel_q;
    logic                hs_keep_q, ls_keep_q, hs_en_q, hs_en_prev_q;
    logic [PA_WIDTH-1:0] pa_wake_en_q;
    logic                pwrdn_q, timeout_q, hs_stable_q, hs_run_prev_q;
    logic [2:0]          sw_cnt_q;
    logic [INT_COUNT-1:0] int_snap_q, int_wake_q;
    logic                wdt_wake_q;
    pmwc_pkg::pmwc_state_t state_q, state_d;
    pmwc_pkg::pmwc_mode_t  mode_q;

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone decode; writes land on the edge where the master sees ack
    wire        wb_req    = wb_cyc_i & wb_stb_i;
    wire        wb_wr     = wb_req & wb_we_i & wb_ack_o & wb_sel_i[0];
    wire        hit_clk   = (wb_adr_i == pmwc_pkg::CLK_CTRL_OFS);
    wire        hit_hs    = (wb_adr_i == pmwc_pkg::HS_OSC_CTRL_OFS);
    wire        hit_stat  = (wb_adr_i == pmwc_pkg::STATUS_OFS);
    wire        hit_pa    = (wb_adr_i == pmwc_pkg::PORTA_WAKE_OFS);
    wire [31:0] rd_clk    = 32'({clk_sel_q, 3'h0, hs_keep_q, ls_keep_q});
    wire [31:0] rd_hs     = 32'({hs_stable_q, hs_en_q});
    wire        sw_pend   = (clk_sel_q != sys_clk_sel_q);
    wire [31:0] rd_stat   = 32'({sw_pend, (state_q != pmwc_pkg::PMWC_ST_RUN),
                                 sys_clk_sel_q, timeout_q, pwrdn_q});
    wire [31:0] rd_pa     = 32'(pa_wake_en_q);
    wire [31:0] rd_mux    = hit_clk  ? rd_clk  :
                            hit_hs   ? rd_hs   :
                            hit_stat ? rd_stat :
                            hit_pa   ? rd_pa   : 32'h0000_0000;

    // Ack one cycle after request, dropped the cycle after; unmapped reads zero
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req & ~wb_ack_o;
            wb_dat_o <= (wb_req & ~wb_ack_o) ? rd_mux : wb_dat_o;
        end
    end

    // Control registers; status bits are read only
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            clk_sel_q    <= pmwc_pkg::CLK_SEL_RST;
            hs_keep_q    <= pmwc_pkg::HS_KEEP_RST;
            ls_keep_q    <= pmwc_pkg::LS_KEEP_RST;
            hs_en_q      <= pmwc_pkg::HS_EN_RST;
            pa_wake_en_q <= '0;
        end else if (wb_wr && hit_clk) begin
            clk_sel_q    <= wb_dat_i[pmwc_pkg::CLK_SEL_LSB +: 3];
            hs_keep_q    <= wb_dat_i[pmwc_pkg::HS_KEEP_BIT];
            ls_keep_q    <= wb_dat_i[pmwc_pkg::LS_KEEP_BIT];
        end else if (wb_wr && hit_hs) begin
            hs_en_q      <= wb_dat_i[pmwc_pkg::HS_EN_BIT];
        end else if (wb_wr && hit_pa) begin
            pa_wake_en_q <= wb_dat_i[PA_WIDTH-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock switching
    wire target_slow = (clk_sel_q == pmwc_pkg::SEL_SUBCLOCK);
    wire cur_slow    = (sys_clk_sel_q == pmwc_pkg::SEL_SUBCLOCK);
    wire target_rdy  = target_slow ? ls_rdy_s2_q : (cur_slow ? hs_stable_q : 1'b1);
    wire running     = (state_q == pmwc_pkg::PMWC_ST_RUN);
    wire sw_count_ok = (sw_cnt_q == pmwc_pkg::SWITCH_CYCLES - 3'h1);
    wire sw_apply    = running & sw_pend & sw_count_ok & target_rdy;

    // apply select after the fixed delay; frozen while halted
    // fixed four periods, then wait only for the target source
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sw_cnt_q      <= 3'h0;
            sys_clk_sel_q <= pmwc_pkg::CLK_SEL_RST;
        end else begin
            sw_cnt_q      <= (!running || !sw_pend || sw_apply) ? 3'h0 :
                             (sw_count_ok ? sw_cnt_q : sw_cnt_q + 3'h1);
            sys_clk_sel_q <= sw_apply ? clk_sel_q : sys_clk_sel_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // High-speed stable flag follows the oscillator's run control and the enable bit
    // cleared on (re)start, set once the ready level is seen
    wire hs_restart = (hs_osc_run_q & ~hs_run_prev_q) | (hs_en_q & ~hs_en_prev_q);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            // Previous levels match the reset levels, so no false start follows reset
            hs_stable_q   <= 1'b0;
            hs_run_prev_q <= 1'b1;
            hs_en_prev_q  <= pmwc_pkg::HS_EN_RST;
        end else begin
            hs_stable_q   <= hs_osc_run_q & ~hs_restart & (hs_stable_q | hs_rdy_s2_q);
            hs_run_prev_q <= hs_osc_run_q;
            hs_en_prev_q  <= hs_en_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Halt entry and wake-up sources
    wire halt_take = running & halt_exec_i;
    // falling edge on an enabled pin; synchronised levels only
    wire [PA_WIDTH-1:0] pa_fall = pa_s3_q & ~pa_s2_q & pa_wake_en_q;
    // requests present at halt entry are masked
    wire [INT_COUNT-1:0] int_new = int_req_i & ~int_snap_q;
    wire in_halt   = (state_q == pmwc_pkg::PMWC_ST_HALT);
    // any of the three sources wakes
    wire wake      = in_halt & ((|pa_fall) | (|int_new) | wdt_overflow_i);
    // oscillator of the applied system clock must be stable
    wire osc_ok    = cur_slow ? ls_rdy_s2_q : hs_stable_q;
    wire restarted = (state_q == pmwc_pkg::PMWC_ST_RESTART) & osc_ok;

    // Mode decoded from keep bits sampled at halt
    // sampled at the halt instruction
    wire [1:0] keep_pair = {hs_keep_q, ls_keep_q};
    pmwc_pkg::pmwc_mode_t mode_pick;
    assign mode_pick = (keep_pair == 2'h0) ? pmwc_pkg::PMWC_MODE_SLEEP :
                       (keep_pair == 2'h1) ? pmwc_pkg::PMWC_MODE_STANDBY_SUBCLOCK_ONLY :
                       (keep_pair == 2'h3) ? pmwc_pkg::PMWC_MODE_STANDBY_BOTH_CLOCKS :
                                             pmwc_pkg::PMWC_MODE_STANDBY_FASTCLOCK_ONLY;

    // Next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            pmwc_pkg::PMWC_ST_RUN:     state_d = halt_exec_i ? pmwc_pkg::PMWC_ST_HALT : state_q;
            pmwc_pkg::PMWC_ST_HALT:    state_d = wake ? pmwc_pkg::PMWC_ST_RESTART : state_q;
            pmwc_pkg::PMWC_ST_RESTART: state_d = osc_ok ? pmwc_pkg::PMWC_ST_RUN : state_q;
            default:                   state_d = pmwc_pkg::PMWC_ST_RUN;
        endcase
    end

    // State, sampled mode, masked requests and wake cause
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q    <= pmwc_pkg::PMWC_ST_RUN;
            mode_q     <= pmwc_pkg::PMWC_MODE_SLEEP;
            int_snap_q <= '0;
            int_wake_q <= '0;
            wdt_wake_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            mode_q     <= halt_take ? mode_pick : mode_q;
            int_snap_q <= halt_take ? int_req_i : int_snap_q;
            int_wake_q <= wake ? int_new : int_wake_q;
            wdt_wake_q <= wake ? wdt_overflow_i : wdt_wake_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags; a set in the same cycle as a clear wins
    // halt sets powerdown; only clear-watchdog clears it
    wire pwrdn_d   = halt_take | (pwrdn_q & ~clr_wdt_exec_i);
    // overflow sets timeout; halt entry clears it
    wire timeout_d = wdt_overflow_i | (timeout_q & ~halt_take);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pwrdn_q   <= 1'b0;
            timeout_q <= 1'b0;
        end else begin
            pwrdn_q   <= pwrdn_d;
            timeout_q <= timeout_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator run controls per mode
    // halted clocks follow the sampled keep bits
    wire halted_d = (state_d == pmwc_pkg::PMWC_ST_HALT);
    pmwc_pkg::pmwc_mode_t mode_eff;
    assign mode_eff = halt_take ? mode_pick : mode_q;
    wire hs_keep_eff = (mode_eff == pmwc_pkg::PMWC_MODE_STANDBY_BOTH_CLOCKS) |
                       (mode_eff == pmwc_pkg::PMWC_MODE_STANDBY_FASTCLOCK_ONLY);
    wire ls_keep_eff = (mode_eff == pmwc_pkg::PMWC_MODE_STANDBY_BOTH_CLOCKS) |
                       (mode_eff == pmwc_pkg::PMWC_MODE_STANDBY_SUBCLOCK_ONLY);
    // Fast mode always needs the high-speed source, whatever the enable says
    wire hs_run_d = halted_d ? hs_keep_eff : (hs_en_q | ~cur_slow | ~target_slow);
    wire ls_run_d = halted_d ? ls_keep_eff : 1'b1;

    // Registered controls; cpu halt also freezes core state, memory and ports
    // execution held from halt until the restart completes
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            hs_osc_run_q      <= 1'b1;
            ls_subclock_run_q <= 1'b1;
            cpu_halt_q        <= 1'b0;
            wdt_run_q         <= 1'b0;
        end else begin
            hs_osc_run_q      <= hs_run_d;
            ls_subclock_run_q <= ls_run_d;
            cpu_halt_q        <= (state_d != pmwc_pkg::PMWC_ST_RUN);
            wdt_run_q         <= wdt_enable_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // One-cycle actions: watchdog clear at entry, resume kind when the restart completes
    // clear the watchdog; it keeps counting only while enabled
    // watchdog wake resets only PC and SP
    // enabled interrupt and free stack: serviced immediately
    // otherwise resume after halt; request left pending
    wire int_take = (|(int_wake_q & int_en_i)) & ~stack_full_i;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wdt_clear_q   <= 1'b0;
            pc_sp_reset_q <= 1'b0;
            int_service_q <= 1'b0;
            resume_next_q <= 1'b0;
        end else begin
            wdt_clear_q   <= halt_take;
            pc_sp_reset_q <= restarted & wdt_wake_q;
            int_service_q <= restarted & ~wdt_wake_q & int_take;
            resume_next_q <= restarted & ~wdt_wake_q & ~int_take;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sleep_entry_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        halt_take && !hs_keep_q && !ls_keep_q |=> cpu_halt_q && !hs_osc_run_q
                                                  && !ls_subclock_run_q)
        else $error("sleep entry left a clock running");

    standby_sub_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        halt_take && !hs_keep_q && ls_keep_q |=> !hs_osc_run_q && ls_subclock_run_q)
        else $error("subclock-only standby clocks wrong");

    standby_both_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        halt_take && hs_keep_q && ls_keep_q |=> hs_osc_run_q && ls_subclock_run_q
                                                && cpu_halt_q)
        else $error("both-clock standby clocks wrong");

    standby_fast_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        halt_take && hs_keep_q && !ls_keep_q |=> hs_osc_run_q && !ls_subclock_run_q)
        else $error("fast-only standby clocks wrong");

    entry_flags_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        halt_take && !wdt_overflow_i |=> pwrdn_q && !timeout_q && wdt_clear_q)
        else $error("halt entry flags wrong");

    pwrdn_clear_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        $fell(pwrdn_q) |-> $past(clr_wdt_exec_i))
        else $error("powerdown flag cleared without clear-watchdog");

    stale_int_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        in_halt && !(|pa_fall) && !wdt_overflow_i && ((int_req_i & ~int_snap_q) == '0)
        |=> state_q == pmwc_pkg::PMWC_ST_HALT)
        else $error("woke on a request present before halt");

    wdt_wake_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        in_halt && wdt_overflow_i |=> timeout_q && state_q == pmwc_pkg::PMWC_ST_RESTART)
        else $error("watchdog overflow did not wake with timeout set");

    resume_stable_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        $fell(cpu_halt_q) |-> $past(osc_ok))
        else $error("resumed before oscillator stable");

    switch_time_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        running && sw_pend && target_rdy && sw_cnt_q == 3'h0 && !halt_exec_i
        && $stable(clk_sel_q) ##1 (target_rdy && running)[*3] |=> !sw_pend)
        else $error("clock switch exceeded four periods");

    hs_flag_start_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        $rose(hs_osc_run_q) |=> !hs_stable_q)
        else $error("stable flag not cleared on oscillator start");

endmodule

/* verilog/pmwc_pkg.sv */
// Package for the power mode and wake-up controller: offsets, fields, resets, states
package pmwc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] CLK_CTRL_OFS     = 8'h00;
    localparam logic [7:0] HS_OSC_CTRL_OFS  = 8'h04;
    localparam logic [7:0] STATUS_OFS       = 8'h08;
    localparam logic [7:0] PORTA_WAKE_OFS   = 8'h0C;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CLK_SEL_LSB      = 5;            // sys_clk_select[2:0] at [7:5]
    localparam int HS_KEEP_BIT      = 1;            // hs_osc_keep_on_halt
    localparam int LS_KEEP_BIT      = 0;            // ls_osc_keep_on_halt
    localparam int HS_EN_BIT        = 0;            // hs_osc_enable
    localparam int HS_STABLE_BIT    = 1;            // hs_osc_stable_flag, read only
    localparam int PWRDN_BIT        = 0;            // powerdown_flag
    localparam int TIMEOUT_BIT      = 1;            // wdt_timeout_flag
    localparam int APPLIED_SEL_LSB  = 2;            // applied select at [4:2]
    localparam int HALTED_BIT       = 5;
    localparam int SW_PEND_BIT      = 6;

    ////////////////////////////////////////////////////////////////////////////
    // Values after reset
    localparam logic [2:0] CLK_SEL_RST   = 3'h0;
    localparam logic       HS_KEEP_RST   = 1'b0;
    localparam logic       LS_KEEP_RST   = 1'b0;
    localparam logic       HS_EN_RST     = 1'b1;

    // Select code that picks the low-speed subclock; 0..6 pick high speed /1../64
    localparam logic [2:0] SEL_SUBCLOCK  = 3'h7;

    ////////////////////////////////////////////////////////////////////////////
    // Timing: fixed part of a clock switch, in ref_clk cycles
    localparam int         SWITCH_PERIODS = 4;
    localparam logic [2:0] SWITCH_CYCLES  = 3'(SWITCH_PERIODS);

    ////////////////////////////////////////////////////////////////////////////
    // Controller states and halt targets
    typedef enum logic [1:0] {
        PMWC_ST_RUN,
        PMWC_ST_HALT,
        PMWC_ST_RESTART
    } pmwc_state_t;

    typedef enum logic [1:0] {
        PMWC_MODE_SLEEP,
        PMWC_MODE_STANDBY_SUBCLOCK_ONLY,
        PMWC_MODE_STANDBY_BOTH_CLOCKS,
        PMWC_MODE_STANDBY_FASTCLOCK_ONLY
    } pmwc_mode_t;

endpackage

/* test/tb_pmwc_top.sv */
// Self-checking bench for the power mode and wake-up controller
`timescale 1ns/10ps
module tb_pmwc_top;
    logic ref_clk, reset_n, cyc, stb, we, halt, clr_wdt, wdt_en, ovf, stk_full, hs_rdy, ls_rdy, ls_ok;
    logic [7:0] adr, porta;
    logic [31:0] wdat, rdat, wb_dat_o;
    logic [3:0] int_req, int_en;
    logic [2:0] sel_q;
    logic wb_ack_o, hs_run, ls_run, cpu_halt_q, wclr, wrun, res_q, isr_q, pcsp_q;
    int miscompares = 0, compares = 0, cyc_cnt = 0, n;
    pmwc_top uut (.ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .halt_exec_i(halt), .clr_wdt_exec_i(clr_wdt), .wdt_enable_i(wdt_en),
        .wdt_overflow_i(ovf), .int_req_i(int_req), .int_en_i(int_en), .stack_full_i(stk_full),
        .porta_i(porta), .hs_osc_ready_i(hs_rdy), .ls_osc_ready_i(ls_rdy),
        .sys_clk_sel_q(sel_q), .hs_osc_run_q(hs_run), .ls_subclock_run_q(ls_run),
        .cpu_halt_q(cpu_halt_q), .wdt_clear_q(wclr), .wdt_run_q(wrun), .resume_next_q(res_q),
        .int_service_q(isr_q), .pc_sp_reset_q(pcsp_q));
    ////////////////////////////////////////////////////////////////////////////
    // Clock, oscillator models and hang guard; ready lags run so restarts take time
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        hs_rdy <= hs_run;
        ls_rdy <= ls_run & ls_ok;
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Classic single cycle: hold until ack is sampled, then release
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    task automatic do_halt();
        @(posedge ref_clk) halt <= 1'b1;
        @(posedge ref_clk) halt <= 1'b0;
        @(posedge ref_clk);
    endtask
    // Wait for the core to restart, then judge the single wake pulse
    task automatic wake_chk(input logic [2:0] exp);
        for (n = 0; n < 60 && cpu_halt_q !== 1'b0; n++) @(posedge ref_clk);
        chk({pcsp_q, isr_q, res_q}, exp);
    endtask
    task automatic final_report();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        wb(0, 8'h00, 0); chk(rdat, 32'h0);
        wb(0, 8'h04, 0); chk(rdat, 32'h3);
        wb(0, 8'h0C, 0); chk(rdat, 32'h0);
        wb(1, 8'h10, 32'hFF); wb(0, 8'h10, 0); chk(rdat, 32'h0);
        $display("reset values done");
    endtask
    task automatic t_clk_switch();
        ls_ok <= 1'b0;
        wb(1, 8'h00, 32'hE0);
        repeat (10) @(posedge ref_clk);
        chk(sel_q, 3'h0);
        ls_ok <= 1'b1;
        for (n = 0; n < 30 && sel_q !== 3'h7; n++) @(posedge ref_clk);
        chk(sel_q, 3'h7);
        // High-speed oscillator off while slow, so the return must wait for it
        wb(1, 8'h04, 32'h0);
        wb(1, 8'h00, 32'h60);
        repeat (5) @(posedge ref_clk);
        chk(sel_q, 3'h7);
        for (n = 0; n < 30 && sel_q !== 3'h3; n++) @(posedge ref_clk);
        chk(sel_q, 3'h3);
        wb(1, 8'h04, 32'h1);
        wb(0, 8'h04, 0); chk(rdat, 32'h1);
        wb(0, 8'h04, 0); chk(rdat, 32'h3);
        wb(1, 8'h00, 32'h00);
        repeat (4) @(posedge ref_clk);
        chk(sel_q, 3'h3);
        repeat (4) @(posedge ref_clk);
        chk(sel_q, 3'h0);
        $display("clock switch done");
    endtask
    task automatic t_halt_modes();
        for (int k = 0; k < 4; k++) begin
            wb(1, 8'h00, k);
            wdt_en <= k[0];
            do_halt();
            chk({cpu_halt_q, wclr, hs_run, ls_run}, {2'b11, k[1:0]});
            chk(wrun, k[0]);
            wb(0, 8'h08, 0); chk(rdat[1:0], 2'b01);
            @(posedge ref_clk) ovf <= 1'b1;
            @(posedge ref_clk) ovf <= 1'b0;
            wake_chk(3'b100);
            wb(0, 8'h08, 0); chk(rdat[1:0], 2'b11);
        end
        @(posedge ref_clk) clr_wdt <= 1'b1;
        @(posedge ref_clk) clr_wdt <= 1'b0;
        wb(0, 8'h08, 0); chk(rdat[0], 1'b0);
        $display("halt modes done");
    endtask
    task automatic t_pin_wake();
        wb(1, 8'h0C, 32'h04);
        do_halt();
        @(posedge ref_clk) porta <= 8'hFD;
        repeat (10) @(posedge ref_clk);
        chk(cpu_halt_q, 1'b1);
        @(posedge ref_clk) porta <= 8'hF9;
        wake_chk(3'b001);
        porta <= 8'hFF;
        $display("pin wake done");
    endtask
    task automatic t_int_wake(input int i, input logic en, input logic full, input logic [2:0] e);
        @(posedge ref_clk);
        int_req <= 4'h8;
        int_en <= {3'b000, en} << i;
        stk_full <= full;
        do_halt();
        repeat (8) @(posedge ref_clk);
        chk(cpu_halt_q, 1'b1);
        int_req <= 4'h8 | (4'h1 << i);
        wake_chk(e);
        int_req <= 4'h0;
        $display("interrupt wake done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        reset_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; wdat = 32'h0;
        halt = 1'b0; clr_wdt = 1'b0; wdt_en = 1'b0; ovf = 1'b0; int_req = 4'h0; int_en = 4'h0;
        stk_full = 1'b0; porta = 8'hFF; ls_ok = 1'b1;
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        t_reset();
        t_clk_switch();
        t_halt_modes();
        t_pin_wake();
        t_int_wake(1, 1'b1, 1'b0, 3'b010);
        t_int_wake(2, 1'b0, 1'b0, 3'b001);
        t_int_wake(0, 1'b1, 1'b1, 3'b001);
        final_report();
    end
endmodule
